// ==== logic/pad_pkg.sv ====
// constants, types and register map of the alarm dial-out controller
package pad_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ        = 10_000_000;   // ref_clk rate
   localparam int unsigned SEC_NS        = 1_000_000_000;
   localparam int unsigned CLK_NS        = SEC_NS / CLK_HZ;
   localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_NS;
   localparam int unsigned HOLD_SEC      = 20;           // wait before hang-up
   localparam logic [1:0]  ALARM_REPEAT  = 2'h3;         // alarm plays per call

   // system messages of the voice module
   localparam logic [7:0]  MSG_PROMPT    = 8'h01;        // ask for password
   localparam logic [7:0]  MSG_PWD_OK    = 8'h02;        // password accepted
   localparam logic [7:0]  MSG_PWD_BAD   = 8'h03;        // password rejected

   // register byte offsets
   localparam logic [4:0]  OFS_CTRL      = 5'h00;
   localparam logic [4:0]  OFS_RING      = 5'h04;
   localparam logic [4:0]  OFS_DIAL_MAX  = 5'h08;
   localparam logic [4:0]  OFS_PWD_MAX   = 5'h0c;
   localparam logic [4:0]  OFS_ALARM_MSG = 5'h10;
   localparam logic [4:0]  OFS_STATUS    = 5'h14;
   localparam logic [4:0]  OFS_IRQ_STAT  = 5'h18;
   localparam logic [4:0]  OFS_IRQ_MASK  = 5'h1c;

   // field positions
   localparam int unsigned CTRL_PWD_EN   = 0;
   localparam int unsigned CTRL_ENABLE   = 1;
   localparam int unsigned IRQ_OK        = 0;
   localparam int unsigned IRQ_FAIL      = 1;
   localparam int unsigned IRQ_ANSWER    = 2;
   localparam int unsigned IRQ_W         = 3;

   // reset values
   localparam logic [1:0]  RST_CTRL      = 2'h2;         // enabled, no password
   localparam logic [7:0]  RST_RING      = 8'h1e;
   localparam logic [7:0]  RST_DIAL_MAX  = 8'h03;
   localparam logic [7:0]  RST_PWD_MAX   = 8'h03;
   localparam logic [7:0]  RST_ALARM_MSG = 8'h05;

   // sequence states
   typedef enum logic [3:0] {
      ST_IDLE, ST_DIAL, ST_RING, ST_PROMPT, ST_WAITPWD, ST_BADPWD,
      ST_GOODPWD, ST_ALARM, ST_HOLD, ST_HANG, ST_DONE
   } pad_state_t;

   // commands to the voice module
   typedef struct packed {
      logic       dial;      // one-cycle pulse: dial the preset number
      logic       hang;      // one-cycle pulse: hang up
      logic       play;      // one-cycle pulse: play msg
      logic [7:0] msg;       // message number, valid with play
   } pad_cmd_t;

   // reports from the voice module
   typedef struct packed {
      logic       answered;  // level: call is off hook
      logic       playDone;  // pulse: playback finished
      logic       pwdValid;  // pulse: password entered
      logic       pwdOk;     // level with pwdValid: password correct
   } pad_stat_t;

endpackage

// ==== logic/pad_dial_ctrl.sv ====
// alarm dial-out sequencer with avalon-mm register slave and interrupt
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - trigger high starts dialing the preset number through the voice module.
// - successful dial-out drives ok output high and fail output low.
// - failed dial-out drives ok output low and fail output high.
// - results stay until trigger goes low, then both clear together.
// - after dialing, wait ring time for an answer before giving up.
// - unanswered attempts redial the same number up to the attempt limit.
// - answered call with password first plays prompt message one.
// - correct password plays message two then alarm message three times.
// - after accepted playback, success is reported after twenty seconds.
// - wrong password plays message three, then back to prompt one.
// - after the allowed wrong entries, stop playback and hang up.
// - when every attempt fails, failure is reported.
// - without password, alarm plays three times, hang up after twenty seconds.
module pad_dial_ctrl
   import pad_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES    // cycles per second tick
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // interrupt
   output var  logic        irq,
   // alarm trigger and results
   input  wire logic        alarm_trigger_in,
   output var  logic        dial_ok_out,
   output var  logic        dial_fail_out,
   // voice module
   output var  pad_cmd_t    voiceCmd,
   input  wire pad_stat_t   voiceStat
);

   //////////////////////////////////////////////////////////////////////////
   // declarations

   localparam int unsigned PRE_W = (SEC_CYC > 1) ? $clog2(SEC_CYC) : 1;

   pad_state_t         state_q, state_d;
   logic [PRE_W-1:0]   pre_q;
   logic [7:0]         sec_q;
   logic               secTick;
   logic [7:0]         tryCnt_q;
   logic [7:0]         badCnt_q;
   logic [1:0]         playCnt_q;
   logic               callOk_q;
   logic               startPlay;
   logic [7:0]         playMsg;
   logic               markOk;
   logic               enter;
   logic               holdTrig_q;
   logic [1:0]         ctrl_q;
   logic [7:0]         ring_q, dialMax_q, pwdMax_q, alarmMsg_q;
   logic [IRQ_W-1:0]   irqStat_q, irqMask_q, irqEvt;
   logic               busWr, busRd;

   //////////////////////////////////////////////////////////////////////////
   // helpers

   // states in which a call is up
   function automatic logic callUp(input pad_state_t s);
      callUp = (s == ST_PROMPT) || (s == ST_WAITPWD) || (s == ST_BADPWD)
            || (s == ST_GOODPWD) || (s == ST_ALARM) || (s == ST_HOLD);
   endfunction

   // read value of a register offset
   function automatic logic [31:0] regRead(input logic [4:0] a);
      regRead = 32'h0000_0000;
      unique case (a)
         OFS_CTRL:      regRead[1:0]  = ctrl_q;
         OFS_RING:      regRead[7:0]  = ring_q;
         OFS_DIAL_MAX:  regRead[7:0]  = dialMax_q;
         OFS_PWD_MAX:   regRead[7:0]  = pwdMax_q;
         OFS_ALARM_MSG: regRead[7:0]  = alarmMsg_q;
         OFS_STATUS:    regRead[19:0] = {dial_fail_out, dial_ok_out, 2'h0,
                                         tryCnt_q, 4'h0, state_q};
         OFS_IRQ_STAT:  regRead[IRQ_W-1:0] = irqStat_q;
         OFS_IRQ_MASK:  regRead[IRQ_W-1:0] = irqMask_q;
         default:       regRead = 32'h0000_0000;
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // second tick and per-state second counter

   assign enter   = (state_d != state_q);
   assign secTick = (pre_q == PRE_W'(SEC_CYC - 1));

   // prescaler restarts on every state change
   always_ff @(posedge ref_clk) begin
      if (!rst_b || enter || secTick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   // seconds spent in the current state, saturating
   always_ff @(posedge ref_clk) begin
      if (!rst_b || enter) begin
         sec_q <= 8'h00;
      end else if (secTick && sec_q != 8'hff) begin
         sec_q <= sec_q + 8'h01;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      state_d   = state_q;
      startPlay = 1'b0;
      playMsg   = alarmMsg_q;
      markOk    = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            // start only on a fresh activation
            if (alarm_trigger_in && !holdTrig_q && ctrl_q[CTRL_ENABLE]) begin
               state_d = ST_DIAL;
            end
         end
         ST_DIAL: begin
            state_d = ST_RING;
         end
         ST_RING: begin
            if (voiceStat.answered) begin
               state_d   = ctrl_q[CTRL_PWD_EN] ? ST_PROMPT : ST_ALARM;
               startPlay = 1'b1;
               playMsg   = ctrl_q[CTRL_PWD_EN] ? MSG_PROMPT : alarmMsg_q;
            end else if (sec_q >= ring_q) begin
               state_d = ST_HANG;
            end
         end
         ST_PROMPT: begin
            if (voiceStat.playDone) begin
               state_d = ST_WAITPWD;
            end
         end
         ST_WAITPWD: begin
            if (voiceStat.pwdValid && voiceStat.pwdOk) begin
               state_d   = ST_GOODPWD;
               startPlay = 1'b1;
               playMsg   = MSG_PWD_OK;
            end else if (voiceStat.pwdValid) begin
               if (badCnt_q + 8'h01 >= pwdMax_q) begin
                  state_d = ST_HANG;
               end else begin
                  state_d   = ST_BADPWD;
                  startPlay = 1'b1;
                  playMsg   = MSG_PWD_BAD;
               end
            end else if (sec_q >= ring_q) begin
               state_d   = ST_PROMPT;
               startPlay = 1'b1;
               playMsg   = MSG_PROMPT;
            end
         end
         ST_BADPWD: begin
            if (voiceStat.playDone) begin
               state_d   = ST_PROMPT;
               startPlay = 1'b1;
               playMsg   = MSG_PROMPT;
            end
         end
         ST_GOODPWD: begin
            if (voiceStat.playDone) begin
               state_d   = ST_ALARM;
               startPlay = 1'b1;
            end
         end
         ST_ALARM: begin
            if (voiceStat.playDone) begin
               if (playCnt_q + 2'h1 >= ALARM_REPEAT) begin
                  state_d = ST_HOLD;
               end else begin
                  startPlay = 1'b1;                                 // replay the alarm
               end
            end
         end
         ST_HOLD: begin
            if (sec_q >= 8'(HOLD_SEC)) begin
               state_d = ST_HANG;
               markOk  = 1'b1;
            end
         end
         ST_HANG: begin
            if (!alarm_trigger_in) begin
               state_d = ST_IDLE;
            end else if (callOk_q) begin
               state_d = ST_DONE;
            end else if (tryCnt_q < dialMax_q) begin
               state_d = ST_DIAL;
            end else begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (!alarm_trigger_in) begin
               state_d = ST_IDLE;
            end
         end
      endcase
      // lost call outside hold, or dropped trigger, ends an active call
      if (callUp(state_q) && state_d != ST_HANG && !markOk &&
          ((!voiceStat.answered && state_q != ST_HOLD) || !alarm_trigger_in)) begin
         state_d   = ST_HANG;
         startPlay = 1'b0;
      end
      if ((state_q == ST_DIAL || state_q == ST_RING) && !alarm_trigger_in) begin
         state_d = ST_HANG;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // sequence registers

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // blocks restart until trigger has been low once
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         holdTrig_q <= 1'b0;
      end else if (!alarm_trigger_in) begin
         holdTrig_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         holdTrig_q <= 1'b1;
      end
   end

   // attempt, wrong-password and alarm-play counters
   always_ff @(posedge ref_clk) begin
      if (!rst_b || state_d == ST_IDLE) begin
         tryCnt_q  <= 8'h00;
         badCnt_q  <= 8'h00;
         playCnt_q <= 2'h0;
      end else if (enter && state_d == ST_DIAL) begin
         tryCnt_q  <= tryCnt_q + 8'h01;
         badCnt_q  <= 8'h00;
         playCnt_q <= 2'h0;
      end else begin
         if (enter && state_d == ST_BADPWD) begin
            badCnt_q <= badCnt_q + 8'h01;
         end
         if (state_q == ST_ALARM && voiceStat.playDone) begin
            playCnt_q <= playCnt_q + 2'h1;
         end
      end
   end

   // outcome of the current attempt
   always_ff @(posedge ref_clk) begin
      if (!rst_b || state_d == ST_IDLE || state_d == ST_DIAL) begin
         callOk_q <= 1'b0;
      end else if (markOk) begin
         callOk_q <= 1'b1;
      end
   end

   // result outputs, held until trigger low
   always_ff @(posedge ref_clk) begin
      if (!rst_b || !alarm_trigger_in) begin
         dial_ok_out   <= 1'b0;
         dial_fail_out <= 1'b0;
      end else if (enter && state_d == ST_DONE) begin
         dial_ok_out   <= callOk_q;
         dial_fail_out <= !callOk_q;
      end
   end

   // command pulses to the voice module
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         voiceCmd <= '0;
      end else begin
         voiceCmd.dial <= enter && (state_d == ST_DIAL);
         voiceCmd.hang <= enter && (state_d == ST_HANG) && (state_q != ST_DIAL)
                          && (state_q != ST_RING || voiceStat.answered);
         voiceCmd.play <= startPlay;
         if (startPlay) begin
            voiceCmd.msg <= playMsg;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // avalon-mm slave: one wait cycle, then answer

   assign busWr = write && !waitrequest;
   assign busRd = read && !waitrequest;

   // waitrequest drops for one cycle per request
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // read data captured as waitrequest drops
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         readdata <= regRead(address);
      end
   end

   // configuration registers, low byte lane only
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ctrl_q     <= RST_CTRL;
         ring_q     <= RST_RING;
         dialMax_q  <= RST_DIAL_MAX;
         pwdMax_q   <= RST_PWD_MAX;
         alarmMsg_q <= RST_ALARM_MSG;
         irqMask_q  <= '0;
      end else if (busWr && byteenable[0]) begin
         unique case (address)
            OFS_CTRL:      ctrl_q     <= writedata[1:0];
            OFS_RING:      ring_q     <= writedata[7:0];
            OFS_DIAL_MAX:  dialMax_q  <= writedata[7:0];
            OFS_PWD_MAX:   pwdMax_q   <= writedata[7:0];
            OFS_ALARM_MSG: alarmMsg_q <= writedata[7:0];
            OFS_IRQ_MASK:  irqMask_q  <= writedata[IRQ_W-1:0];
            default:       ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // interrupt status: sticky, write one to clear, set wins

   assign irqEvt[IRQ_OK]     = enter && state_d == ST_DONE && callOk_q;
   assign irqEvt[IRQ_FAIL]   = enter && state_d == ST_DONE && !callOk_q;
   assign irqEvt[IRQ_ANSWER] = state_q == ST_RING && callUp(state_d);

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irqStat_q <= '0;
      end else if (busWr && byteenable[0] && address == OFS_IRQ_STAT) begin
         irqStat_q <= (irqStat_q & ~writedata[IRQ_W-1:0]) | irqEvt;
      end else begin
         irqStat_q <= irqStat_q | irqEvt;
      end
   end

   // level interrupt from masked status
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irqStat_q | irqEvt) & irqMask_q);
      end
   end

endmodule

`default_nettype wire

// ==== test/pad_dial_ctrl_asserts.sv ====
// port checks for the alarm dial-out controller
`timescale 1ns/1ps
`default_nettype none
module pad_dial_ctrl_asserts
   import pad_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES   // cycles per second tick
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // avalon-mm slave
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        irq,
   // trigger, results and voice module
   input wire logic        alarm_trigger_in,
   input wire logic        dial_ok_out,
   input wire logic        dial_fail_out,
   input wire pad_cmd_t    voiceCmd,
   input wire pad_stat_t   voiceStat
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic [31:0] quietCnt_q;
   ////////////////////////////////////////////////////////////////////////////////
   // cycles since the last play command, saturating
   always_ff @(posedge ref_clk) begin
      if (!rst_b || voiceCmd.play) begin
         quietCnt_q <= 32'h0;
      end else if (quietCnt_q != 32'hffffffff) begin
         quietCnt_q <= quietCnt_q + 32'h1;
      end
   end
   // playback of one message up to its completion
   sequence s_done_after(logic [7:0] m);
      voiceCmd.play && voiceCmd.msg == m ##[1:10] voiceStat.playDone;
   endsequence
   sequence s_play_next;
      ##[1:3] voiceCmd.play;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // bus handshake and result outputs
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest not low one cycle after request");
   a_wait_short: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_result_excl: assert property (!(dial_ok_out && dial_fail_out))
      else $error("success and failure high together");
   a_clear_both: assert property (!alarm_trigger_in |=> !dial_ok_out && !dial_fail_out)
      else $error("result not cleared after trigger low");
   a_hold_result: assert property ((dial_ok_out || dial_fail_out) && alarm_trigger_in
      |=> $stable({dial_ok_out, dial_fail_out}))
      else $error("result changed while trigger high");
   a_dial_trig: assert property (voiceCmd.dial |-> $past(alarm_trigger_in))
      else $error("dial without trigger");
   a_one_seq: assert property ((dial_ok_out || dial_fail_out) |-> !voiceCmd.dial)
      else $error("dial while result stands");
   // message order after answer and password entry
   a_answer_play: assert property ($rose(voiceStat.answered) |-> s_play_next)
      else $error("no playback after answer");
   a_bad_reprompt: assert property (s_done_after(MSG_PWD_BAD)
      |-> ##[1:3] (voiceCmd.play && voiceCmd.msg == MSG_PROMPT))
      else $error("no prompt after wrong password");
   a_good_alarm: assert property (s_done_after(MSG_PWD_OK) |-> ##[1:3] (voiceCmd.play
      && voiceCmd.msg != MSG_PROMPT && voiceCmd.msg != MSG_PWD_BAD))
      else $error("no alarm after accepted password");
   a_hold_quiet: assert property ($rose(dial_ok_out) |-> quietCnt_q >= HOLD_SEC * SEC_CYC)
      else $error("success before hold time");
endmodule
bind pad_dial_ctrl pad_dial_ctrl_asserts #(.SEC_CYC(SEC_CYC)) i_pad_dial_ctrl_asserts (
   .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
   .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .irq(irq), .alarm_trigger_in(alarm_trigger_in),
   .dial_ok_out(dial_ok_out), .dial_fail_out(dial_fail_out), .voiceCmd(voiceCmd),
   .voiceStat(voiceStat));
`default_nettype wire

// ==== test/pad_voice_model.sv ====
// behavioural voice module and called party
`timescale 1ns/1ps
`default_nettype none
module pad_voice_model
   import pad_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // commands and test knobs
   input  wire pad_cmd_t   voiceCmd,
   input  wire logic       answerOn,   // called party picks up
   input  wire logic [1:0] pwdMode,    // 0 none, 1 right, 2 wrong
   // reports
   output var  pad_stat_t  voiceStat
);
   logic [3:0] ringCnt_q;
   logic [3:0] playCnt_q;
   logic [3:0] pwdCnt_q;
   logic [7:0] msg_q;
   // answer, playback and keypad timers
   always_ff @(posedge ref_clk) begin
      voiceStat.playDone <= 1'b0;
      voiceStat.pwdValid <= 1'b0;
      voiceStat.pwdOk <= ~voiceStat.pwdOk;   // qualifier toggles between reports
      if (ringCnt_q != 4'h0) ringCnt_q <= ringCnt_q - 4'h1;
      if (ringCnt_q == 4'h1) voiceStat.answered <= 1'b1;
      if (playCnt_q != 4'h0) playCnt_q <= playCnt_q - 4'h1;
      if (playCnt_q == 4'h1) begin
         voiceStat.playDone <= 1'b1;
         if (msg_q == MSG_PROMPT && pwdMode != 2'h0) pwdCnt_q <= 4'h2;
      end
      if (pwdCnt_q != 4'h0) pwdCnt_q <= pwdCnt_q - 4'h1;
      if (pwdCnt_q == 4'h1) begin
         voiceStat.pwdValid <= 1'b1;
         voiceStat.pwdOk <= (pwdMode == 2'h1);
      end
      if (voiceCmd.dial && answerOn) ringCnt_q <= 4'h3;
      if (voiceCmd.play) begin
         playCnt_q <= 4'h4;
         msg_q <= voiceCmd.msg;
      end
      if (voiceCmd.hang || !rst_b) begin
         voiceStat <= '0;
         ringCnt_q <= 4'h0;
         playCnt_q <= 4'h0;
         pwdCnt_q <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// ==== test/test_pad_dial_ctrl.sv ====
// self-checking bench of the alarm dial-out controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module test_pad_dial_ctrl
   import pad_pkg::*;
;
   localparam int unsigned SEC = 10;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic        alarm_trigger_in = 1'b0;
   logic        answerOn = 1'b0;
   logic [1:0]  pwdMode = 2'h0;
   logic [4:0]  address = 5'h0;
   logic [3:0]  byteenable = 4'h1;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest, irq, dial_ok_out, dial_fail_out;
   pad_cmd_t    voiceCmd;
   pad_stat_t   voiceStat;
   int          failures = 0, comparisons = 0, cyc = 0;
   int          dials, hangs, lastDial, dialGap, lastPlay, hangGap;
   int          plays [8];
   ////////////////////////////////////////////////////////////////////////////////
   pad_dial_ctrl #(.SEC_CYC(SEC)) i_pad_dial_ctrl (
      .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .alarm_trigger_in(alarm_trigger_in),
      .dial_ok_out(dial_ok_out), .dial_fail_out(dial_fail_out), .voiceCmd(voiceCmd),
      .voiceStat(voiceStat));
   pad_voice_model i_pad_voice_model (.ref_clk(ref_clk), .rst_b(rst_b), .voiceCmd(voiceCmd),
      .answerOn(answerOn), .pwdMode(pwdMode), .voiceStat(voiceStat));
   always #50 ref_clk = ~ref_clk;
   // command counters, cleared while trigger is low
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (!alarm_trigger_in) begin
         dials <= 0;
         hangs <= 0;
         plays <= '{default: 0};
      end
      if (voiceCmd.dial) begin
         dials <= dials + 1;
         dialGap <= cyc - lastDial;
         lastDial <= cyc;
      end
      if (voiceCmd.hang) begin
         hangs <= hangs + 1;
         hangGap <= cyc - lastPlay;
      end
      if (voiceCmd.play) begin
         plays[voiceCmd.msg[2:0]] <= plays[voiceCmd.msg[2:0]] + 1;
         lastPlay <= cyc;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 20) begin
         failures++;
         finish_test();
      end
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e);
   endtask
   // bounded wait for either result
   task automatic wait_res();
      int n;
      n = 0;
      while (dial_ok_out !== 1'b1 && dial_fail_out !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 3000) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic stop_trig();
      alarm_trigger_in <= 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK({dial_ok_out, dial_fail_out}, 2'b00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reset values, an unmapped address and the read-only status
   task automatic t_regs();
      logic [4:0]  ofs [7] = '{OFS_CTRL, OFS_RING, OFS_DIAL_MAX, OFS_PWD_MAX,
                               OFS_ALARM_MSG, OFS_IRQ_MASK, 5'h02};
      logic [31:0] rv [7] = '{32'h2, 32'h1e, 32'h3, 32'h3, 32'h5, 32'h0, 32'h0};
      for (int i = 0; i < 7; i++) begin
         rd(ofs[i], rv[i]);
      end
      wr(OFS_STATUS, 32'hffffffff);
      rd(OFS_STATUS, 32'h0);
   endtask
   task automatic t_nopwd();
      wr(OFS_ALARM_MSG, 32'h7);
      wr(OFS_IRQ_MASK, 32'h1);
      answerOn <= 1'b1;
      alarm_trigger_in <= 1'b1;
      wait_res();
      `CHK({dial_ok_out, dial_fail_out}, 2'b10);
      `CHK(plays[7], 3);
      `CHK(hangGap >= HOLD_SEC * SEC, 1'b1);
      repeat (40) @(posedge ref_clk);
      `CHK(dials, 1);
      `CHK({dial_ok_out, irq}, 2'b11);
      stop_trig();
      wr(OFS_IRQ_STAT, 32'h7);
      rd(OFS_IRQ_STAT, 32'h0);
      `CHK(irq, 1'b0);
   endtask
   task automatic t_noanswer();
      wr(OFS_RING, 32'h2);
      wr(OFS_DIAL_MAX, 32'h2);
      answerOn <= 1'b0;
      alarm_trigger_in <= 1'b1;
      wait_res();
      `CHK({dial_ok_out, dial_fail_out}, 2'b01);
      `CHK(dials, 2);
      `CHK(dialGap >= 2 * SEC && dialGap <= 4 * SEC, 1'b1);
      `CHK(hangs, 0);
      rd(OFS_STATUS, 32'h0008020a);
      rd(OFS_IRQ_STAT, 32'h2);
      `CHK(irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h2);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b1);
      wr(OFS_IRQ_STAT, 32'h2);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0);
      stop_trig();
   endtask
   task automatic t_pwdok();
      wr(OFS_CTRL, 32'h3);
      answerOn <= 1'b1;
      pwdMode <= 2'h1;
      alarm_trigger_in <= 1'b1;
      wait_res();
      `CHK({dial_ok_out, dial_fail_out}, 2'b10);
      `CHK(plays[1], 1);
      `CHK(plays[2], 1);
      `CHK(plays[7], 3);
      `CHK(plays[3], 0);
      stop_trig();
   endtask
   task automatic t_pwdbad();
      wr(OFS_PWD_MAX, 32'h2);
      wr(OFS_DIAL_MAX, 32'h1);
      pwdMode <= 2'h2;
      alarm_trigger_in <= 1'b1;
      wait_res();
      `CHK({dial_ok_out, dial_fail_out}, 2'b01);
      `CHK(plays[1], 2);
      `CHK(plays[3], 1);
      `CHK(plays[7], 0);
      `CHK(hangs, 1);
      `CHK(dials, 1);
      stop_trig();
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_nopwd();
      t_noanswer();
      t_pwdok();
      t_pwdbad();
      finish_test();
   end
endmodule
`default_nettype wire
